// ---- verilog/iod_pkg.sv ----
// iod_pkg: constants, register map and carrier types of the output data registers
// assumes a 20 MHz system clock and a 16-bit word register map on the serial link
`default_nettype none
package iod_pkg;
  localparam int              CLK_HZ            = 20_000_000;
  localparam int              SAMPLE_RATE_SPS   = 2000;
  localparam int              SAMPLE_PERIOD_DEF = CLK_HZ / SAMPLE_RATE_SPS;
  localparam real             TS_LSB_US         = 49.02;
  localparam int              TS_LSB_CYC        = int'($floor(TS_LSB_US * CLK_HZ / 1.0E6));
  localparam int              GYRO_CNT_PER_DPS  = 10;
  localparam int              DANG_FS_DEG       = 2160;
  // delta angle scale: 2^31 / (2 * fs * 10 * 2160), held with 16 fraction bits
  localparam longint          DANG_K_FULL       = (64'sh1 <<< 47) /
    (longint'(2 * SAMPLE_RATE_SPS) * GYRO_CNT_PER_DPS * DANG_FS_DEG);
  localparam logic signed [22:0] DANG_K_Q16     = 23'(DANG_K_FULL);

  localparam logic [2:0][6:0] OFS_RATE_LOW   = {7'h0C, 7'h08, 7'h04};
  localparam logic [2:0][6:0] OFS_RATE_HIGH  = {7'h0E, 7'h0A, 7'h06};
  localparam logic [2:0][6:0] OFS_ACCEL_LOW  = {7'h18, 7'h14, 7'h10};
  localparam logic [2:0][6:0] OFS_ACCEL_HIGH = {7'h1A, 7'h16, 7'h12};
  localparam logic [2:0][6:0] OFS_DANG_LOW   = {7'h2C, 7'h28, 7'h24};
  localparam logic [2:0][6:0] OFS_DANG_HIGH  = {7'h2E, 7'h2A, 7'h26};
  localparam logic [6:0]      OFS_TEMP       = 7'h1C;
  localparam logic [6:0]      OFS_TSTAMP     = 7'h1E;
  localparam logic [6:0]      OFS_COUNT      = 7'h22;
  localparam logic [6:0]      OFS_MISC       = 7'h60;
  localparam logic [6:0]      OFS_DEC        = 7'h64;
  localparam logic [6:0]      OFS_CMD        = 7'h68;

  localparam int              MISC_SYNC_LSB    = 2;
  localparam logic [2:0]      SYNC_MODE_SCALED = 3'h2;
  localparam int              CMD_SRST_BIT     = 7;
  localparam logic [15:0]     ACCEL_HI_MAX     = 16'h7D00;
  localparam logic [15:0]     ACCEL_HI_MIN     = 16'h8300;
  localparam logic [15:0]     MISC_RST         = 16'h0000;
  localparam logic [15:0]     DEC_RST          = 16'h0000;
  localparam logic [15:0]     COUNT_RST        = 16'h0000;
  localparam logic [3:0]      PIN_RST          = 4'h3;
  localparam int              PIN_SCLK         = 0;
  localparam int              PIN_CS           = 1;
  localparam int              PIN_MOSI         = 2;
  localparam int              PIN_SYNC         = 3;

  typedef struct packed {
    logic [2:0][31:0] rate;
    logic [2:0][31:0] accel;
    logic [15:0]      temp;
  } iod_sample_t;

  typedef struct packed {
    logic       wr;
    logic [6:0] addr;
    logic [7:0] data;
  } iod_frame_t;
endpackage : iod_pkg
`default_nettype wire

// ---- verilog/iod_output_regs.sv ----
// iod_output_regs: output data registers with decimation, delta angle and serial access
// assumes front-end samples on clk, serial pins and sync pin asynchronous to clk
//
// Contract
// - accel high words are 16-bit two's complement, 0 g is 0x0000, 1 LSB is 1.25 mg.
// - accel low words extend the high words into one 32-bit two's complement value.
// - accel range is +/-40 g, the high word saturating at 0x7D00 and 0x8300.
// - the temperature word is two's complement, 0x0000 at 0 C, 1 LSB is 0.1 C.
// - the time stamp counts time since the last sync pulse in 49.02 us steps; the code steps every 980 clk cycles, 49.00 us at 20 MHz.
// - the time stamp is meaningful when the sync mode field bits 4:2 hold 010.
// - each update loads the time stamp taken at the last sample of that update.
// - the update counter clears to 0x0000 at power-on and on a reset command.
// - the update counter steps by one per update and wraps from 0xFFFF to 0x0000.
// - the update counter reads as a 16-bit unsigned count over the whole word.
// - delta angle is the sum of adjacent rate pairs over a period over 2 fs.
// - each delta angle covers the decimation setting plus one samples.
// - the internal sample clock runs at a nominal 2000 samples per second.
// - each delta angle axis is two 16-bit words forming one 32-bit value.
// - rate high words are two's complement, 0x0000 at rest, 1 LSB 0.1 deg/s.
`timescale 1ns/1ps
`default_nettype none
module iod_output_regs
  import iod_pkg::*;
#(
  parameter int SAMPLE_PERIOD_CYC = SAMPLE_PERIOD_DEF
)
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        spi_sclk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_mosi,
  input  wire logic        sync_in,
  input  wire iod_sample_t sample_i,
  output var  logic        spi_miso,
  output var  logic        spi_miso_oe,
  output var  logic        data_ready
);

  // pin synchronisers: a level counts once the second and third stages agree
  logic [3:0] pin_m_q;
  logic [3:0] pin_s2_q;
  logic [3:0] pin_s3_q;
  logic [3:0] pin_lvl_q;
  logic [3:0] pin_prev_q;
  wire  logic [3:0] pins_w = {sync_in, spi_mosi, spi_cs_n, spi_sclk};
  wire  logic [3:0] pin_lvl_d = (pin_s2_q & pin_s3_q) |
                                (pin_lvl_q & (pin_s2_q | pin_s3_q));
  wire  logic [3:0] rise_w = pin_lvl_q & ~pin_prev_q;
  wire  logic [3:0] fall_w = ~pin_lvl_q & pin_prev_q;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pin_m_q    <= PIN_RST;
      pin_s2_q   <= PIN_RST;
      pin_s3_q   <= PIN_RST;
      pin_lvl_q  <= PIN_RST;
      pin_prev_q <= PIN_RST;
    end
    else
    begin
      pin_m_q    <= pins_w;
      pin_s2_q   <= pin_m_q;
      pin_s3_q   <= pin_s2_q;
      pin_lvl_q  <= pin_lvl_d;
      pin_prev_q <= pin_lvl_q;
    end
  end

  wire logic cs_act    = ~pin_lvl_q[PIN_CS];
  wire logic cs_fall   = fall_w[PIN_CS];
  wire logic mosi_w    = pin_lvl_q[PIN_MOSI];
  wire logic sync_rise = rise_w[PIN_SYNC];

  // serial frame: write flag, 7-bit address, data byte; reads answer in next frame
  logic [15:0] rx_q;
  logic [15:0] tx_q;
  logic [3:0]  bit_q;
  logic [15:0] rd_word;
  iod_frame_t  frame_w;
  wire  logic  bit_edge   = cs_act & rise_w[PIN_SCLK];
  wire  logic  frame_done = bit_edge & (bit_q == 4'hF);
  assign frame_w = iod_frame_t'({rx_q[14:0], mosi_w});
  wire  logic [6:0] rd_addr = {frame_w.addr[6:1], 1'h0};
  wire  logic  write_w    = frame_done & frame_w.wr;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rx_q     <= 16'h0000;
      tx_q     <= 16'h0000;
      bit_q    <= 4'h0;
      spi_miso <= 1'h0;
    end
    else if (cs_fall)
    begin
      bit_q    <= 4'h0;
      spi_miso <= tx_q[15];
    end
    else if (bit_edge)
    begin
      rx_q  <= {rx_q[14:0], mosi_w};
      bit_q <= bit_q + 4'h1;
      if (frame_done)
      begin
        tx_q     <= rd_word;
        spi_miso <= rd_word[15];
      end
      else
      begin
        tx_q     <= {tx_q[14:0], 1'h0};
        spi_miso <= tx_q[14];
      end
    end
  end

  // control words written by the host
  logic [15:0] misc_q;
  logic [15:0] dec_q;
  wire  logic [15:0] wr_merge_misc = frame_w.addr[0] ? {frame_w.data, misc_q[7:0]}
                                                     : {misc_q[15:8], frame_w.data};
  wire  logic [15:0] wr_merge_dec  = frame_w.addr[0] ? {frame_w.data, dec_q[7:0]}
                                                     : {dec_q[15:8], frame_w.data};
  wire  logic misc_hit   = write_w & (rd_addr == OFS_MISC);
  wire  logic dec_hit    = write_w & (rd_addr == OFS_DEC);
  wire  logic soft_rst_w = write_w & (frame_w.addr == OFS_CMD) & frame_w.data[CMD_SRST_BIT];
  wire  logic scaled_w   = misc_q[MISC_SYNC_LSB +: 3] == SYNC_MODE_SCALED;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      misc_q <= MISC_RST;
      dec_q  <= DEC_RST;
    end
    else
    begin
      if (misc_hit)
        misc_q <= wr_merge_misc;
      if (dec_hit)
        dec_q <= wr_merge_dec;
    end
  end

  // internal sample clock and decimation
  logic [15:0] tick_cnt_q;
  logic [15:0] smp_cnt_q;
  wire  logic  tick_w  = tick_cnt_q == 16'(SAMPLE_PERIOD_CYC - 1);
  wire  logic  first_w = smp_cnt_q == 16'h0000;
  wire  logic  upd_w   = tick_w & (smp_cnt_q == dec_q) & ~soft_rst_w;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tick_cnt_q <= 16'h0000;
      smp_cnt_q  <= 16'h0000;
    end
    else
    begin
      tick_cnt_q <= tick_w ? 16'h0000 : tick_cnt_q + 16'h0001;
      if (soft_rst_w || (tick_w && smp_cnt_q == dec_q))
        smp_cnt_q <= 16'h0000;
      else if (tick_w)
        smp_cnt_q <= smp_cnt_q + 16'h0001;
    end
  end

  // sync-relative time stamp
  logic [15:0] ts_div_q;
  logic [15:0] ts_cnt_q;
  logic [15:0] ts_q;
  wire  logic  ts_step = ts_div_q == 16'(TS_LSB_CYC - 1);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ts_div_q <= 16'h0000;
      ts_cnt_q <= 16'h0000;
      ts_q     <= 16'h0000;
    end
    else
    begin
      if (sync_rise)
      begin
        ts_div_q <= 16'h0000;
        ts_cnt_q <= 16'h0000;
      end
      else if (ts_step)
      begin
        ts_div_q <= 16'h0000;
        ts_cnt_q <= ts_cnt_q + 16'h0001;
      end
      else
        ts_div_q <= ts_div_q + 16'h0001;
      if (upd_w)
        ts_q <= scaled_w ? ts_cnt_q : 16'h0000;
    end
  end

  // update counter and data ready flag
  logic [15:0] cnt_q;
  logic [15:0] temp_q;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_q      <= COUNT_RST;
      temp_q     <= 16'h0000;
      data_ready <= 1'h0;
      spi_miso_oe <= 1'h0;
    end
    else
    begin
      if (soft_rst_w)
        cnt_q <= COUNT_RST;
      else if (upd_w)
        cnt_q <= cnt_q + 16'h0001;
      if (upd_w)
        temp_q <= sample_i.temp;
      if (upd_w)
        data_ready <= 1'h1;
      else if (cs_fall)
        data_ready <= 1'h0;
      spi_miso_oe <= cs_act;
    end
  end

  // per-axis rate, acceleration and delta angle
  logic [2:0][31:0] rate_q;
  logic [2:0][31:0] accel_q;
  logic [2:0][31:0] dang_q;
  logic [2:0][15:0] prev_q;
  logic [2:0][33:0] acc_q;
  logic [2:0][15:0] ax_rd;

  for (genvar i = 0; i < 3; i++)
  begin : g_axis
    wire logic [15:0] rate_hi = sample_i.rate[i][31:16];
    wire logic [16:0] pair_w  = {rate_hi[15], rate_hi} + {prev_q[i][15], prev_q[i]};
    wire logic [33:0] pair_x  = {{17{pair_w[16]}}, pair_w};
    wire logic [33:0] acc_new = first_w ? pair_x : acc_q[i] + pair_x;
    wire logic signed [56:0] prod_w = $signed(acc_new) * DANG_K_Q16;
    wire logic [31:0] accel_in = sample_i.accel[i];
    wire logic over_w  = $signed(accel_in) > $signed({ACCEL_HI_MAX, 16'h0000});
    wire logic under_w = $signed(accel_in) < $signed({ACCEL_HI_MIN, 16'h0000});
    wire logic [31:0] accel_sat = over_w  ? {ACCEL_HI_MAX, 16'h0000} :
                                  under_w ? {ACCEL_HI_MIN, 16'h0000} : accel_in;

    always_ff @(posedge clk or posedge sys_rst)
    begin
      if (sys_rst)
      begin
        acc_q[i]   <= 34'h000000000;
        prev_q[i]  <= 16'h0000;
        rate_q[i]  <= 32'h00000000;
        accel_q[i] <= 32'h00000000;
        dang_q[i]  <= 32'h00000000;
      end
      else
      begin
        if (soft_rst_w)
        begin
          acc_q[i]  <= 34'h000000000;
          prev_q[i] <= 16'h0000;
        end
        else if (tick_w)
        begin
          acc_q[i]  <= acc_new;
          prev_q[i] <= rate_hi;
        end
        if (upd_w)
        begin
          rate_q[i]  <= sample_i.rate[i];
          accel_q[i] <= accel_sat;
          dang_q[i]  <= prod_w[47:16];
        end
      end
    end

    assign ax_rd[i] =
      (rd_addr == OFS_RATE_LOW[i])   ? rate_q[i][15:0]  :
      (rd_addr == OFS_RATE_HIGH[i])  ? rate_q[i][31:16] :
      (rd_addr == OFS_ACCEL_LOW[i])  ? accel_q[i][15:0] :
      (rd_addr == OFS_ACCEL_HIGH[i]) ? accel_q[i][31:16] :
      (rd_addr == OFS_DANG_LOW[i])   ? dang_q[i][15:0]  :
      (rd_addr == OFS_DANG_HIGH[i])  ? dang_q[i][31:16] : 16'h0000;

    AST_ACCEL_RANGE: assert property (@(posedge clk) disable iff (sys_rst)
      ($signed(accel_q[i][31:16]) <= $signed(ACCEL_HI_MAX)) &&
      ($signed(accel_q[i][31:16]) >= $signed(ACCEL_HI_MIN)))
      else $error("acceleration high word beyond 40 g");

    AST_RATE_LOAD: assert property (@(posedge clk) disable iff (sys_rst)
      upd_w |=> rate_q[i] == $past(sample_i.rate[i]))
      else $error("rate word not loaded from the update sample");

    AST_DANG_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
      !upd_w |=> $stable(dang_q[i]))
      else $error("delta angle changed outside an update");
  end

  wire logic [15:0] sc_rd =
    (rd_addr == OFS_TEMP)   ? temp_q :
    (rd_addr == OFS_TSTAMP) ? ts_q   :
    (rd_addr == OFS_COUNT)  ? cnt_q  :
    (rd_addr == OFS_MISC)   ? misc_q :
    (rd_addr == OFS_DEC)    ? dec_q  : 16'h0000;
  assign rd_word = ax_rd[0] | ax_rd[1] | ax_rd[2] | sc_rd;

  AST_CNT_STEP: assert property (@(posedge clk) disable iff (sys_rst)
    upd_w |=> cnt_q == 16'($past(cnt_q) + 16'h0001))
    else $error("update counter did not step by one");

  AST_CNT_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
    soft_rst_w |=> cnt_q == COUNT_RST)
    else $error("update counter not cleared by reset command");

  AST_CNT_ONLY_UPD: assert property (@(posedge clk) disable iff (sys_rst)
    !$stable(cnt_q) |-> $past(upd_w) || $past(soft_rst_w))
    else $error("update counter moved without an update");

  AST_TS_LOAD: assert property (@(posedge clk) disable iff (sys_rst)
    upd_w && scaled_w |=> ts_q == $past(ts_cnt_q))
    else $error("time stamp not taken at the update sample");

  AST_TS_UNSCALED: assert property (@(posedge clk) disable iff (sys_rst)
    upd_w && !scaled_w |=> ts_q == 16'h0000)
    else $error("time stamp loaded outside scaled sync mode");

  AST_TS_SYNC: assert property (@(posedge clk) disable iff (sys_rst)
    sync_rise |=> ts_cnt_q == 16'h0000 ##1 ts_cnt_q == 16'h0000)
    else $error("time stamp not restarted by sync edge");

  AST_TICK_GAP: assert property (@(posedge clk) disable iff (sys_rst)
    tick_w |=> !tick_w [*8])
    else $error("sample ticks too close together");

  AST_DEC_COUNT: assert property (@(posedge clk) disable iff (sys_rst)
    upd_w |-> tick_w && smp_cnt_q == dec_q ##1 smp_cnt_q == 16'h0000)
    else $error("update not at the end of a decimation period");

endmodule : iod_output_regs
`default_nettype wire

// ---- tb/iod_host_model.sv ----
// iod_host_model: serial host that clocks 16-bit frames into the output registers
// assumes 20 MHz clk; sclk idles high with a 400 ns period; frames are started by the bench
`timescale 1ns/1ps
`default_nettype none
module iod_host_model
  import iod_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        spi_miso,
  input  wire logic        spi_miso_oe,
  output var  logic        spi_sclk,
  output var  logic        spi_cs_n,
  output var  logic        spi_mosi,
  output var  logic [15:0] rx_word,
  output var  logic        rx_valid
);
  initial
  begin
    spi_sclk = 1'b1;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
    rx_word  = 16'h0000;
    rx_valid = 1'b0;
  end

  task automatic xfer(input logic [15:0] tx);
    logic [15:0] rx;
    @(posedge clk);
    spi_cs_n <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = 15; i >= 0; i--)
    begin
      spi_sclk <= 1'b0;
      spi_mosi <= tx[i];
      repeat (3) @(posedge clk);
      // a released output is not trusted
      rx[i] = spi_miso_oe ? spi_miso : 1'bx;
      @(posedge clk);
      spi_sclk <= 1'b1;
      repeat (4) @(posedge clk);
    end
    repeat (4) @(posedge clk);
    spi_cs_n <= 1'b1;
    // deselected data line shows the inverse of the last bit
    spi_mosi <= ~tx[0];
    rx_word  <= rx;
    rx_valid <= 1'b1;
    @(posedge clk);
    rx_valid <= 1'b0;
  endtask : xfer
endmodule : iod_host_model
`default_nettype wire

// ---- tb/iod_output_regs_bench.sv ----
// iod_output_regs_bench: reads the output words through the host model and compares
// assumes a shortened sample period; expectations come from the sample inputs
`timescale 1ns/1ps
`default_nettype none
module iod_output_regs_bench;
  import iod_pkg::*;
  localparam int P     = 40;
  localparam int DEC   = 255;
  localparam int LIMIT = 70000;
  typedef struct {
    logic        chk;
    logic [15:0] val;
    string       name;
  } iod_exp_t;

  logic        clk;
  logic        sys_rst;
  logic        sync_in;
  iod_sample_t sample_i;
  logic        spi_sclk;
  logic        spi_cs_n;
  logic        spi_mosi;
  logic        spi_miso;
  logic        spi_miso_oe;
  logic        data_ready;
  logic [15:0] rx_word;
  logic        rx_valid;
  int          fail_count;
  int          checked;
  int          cyc;
  int          seed;
  iod_exp_t    exp_q[$];
  logic [31:0] acc_exp[3];
  logic [31:0] dang;
  logic [15:0] cnt1;
  int          t1;
  int          t2;

  iod_output_regs #(.SAMPLE_PERIOD_CYC(P)) iod_output_regs_inst (
    .clk(clk), .sys_rst(sys_rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .sync_in(sync_in), .sample_i(sample_i), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .data_ready(data_ready));

  iod_host_model iod_host_model_inst (
    .clk(clk), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .rx_word(rx_word), .rx_valid(rx_valid));

  always #25 clk = ~clk;

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  task automatic check(string name, logic [31:0] seen, logic [31:0] expv);
    checked++;
    if (seen !== expv)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, expv, seen);
    end
  endtask : check

  // the note pushed with a frame is judged against the answer of the next frame
  task automatic frame(logic wr, logic [6:0] a, logic [7:0] d, logic chk, logic [15:0] v,
                       string nm);
    exp_q.push_back('{chk, v, nm});
    iod_host_model_inst.xfer({wr, a, d});
    repeat (8) @(posedge clk);
  endtask : frame

  task automatic wait_ready(output int t);
    while (data_ready !== 1'b1)
      @(negedge clk);
    t = cyc;
  endtask : wait_ready

  function automatic logic [31:0] sat(logic signed [31:0] v);
    if (v > 32'sh7D000000)
      return 32'h7D000000;
    if (v < $signed(32'h83000000))
      return 32'h83000000;
    return v;
  endfunction : sat

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      fail_count++;
      summarize();
    end
  end

  always @(posedge clk)
  begin
    iod_exp_t e;
    if (rx_valid === 1'b1 && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      if (e.chk)
        check(e.name, {16'h0000, rx_word}, {16'h0000, e.val});
    end
  end

  initial
  begin
    clk = 1'b0;
    sys_rst = 1'b1;
    sync_in = 1'b0;
    cyc = 0;
    fail_count = 0;
    checked = 0;
    seed = 32'h0E09;
    sample_i = '0;
    sample_i.accel[0] = 32'h7FFF0000;
    sample_i.accel[1] = 32'h80000001;
    sample_i.accel[2] = $random(seed) >>> 2;
    sample_i.temp = 16'($random(seed));
    sample_i.rate[0] = {16'($random(seed)) & 16'h03FF, 16'h0000};
    sample_i.rate[1] = $random(seed);
    sample_i.rate[2] = $random(seed);
    for (int i = 0; i < 3; i++)
      acc_exp[i] = sat(sample_i.accel[i]);
    dang = 32'((longint'(2 * (DEC + 1)) * longint'(sample_i.rate[0][31:16]) *
                longint'(DANG_K_Q16)) >>> 16);
    exp_q.push_back('{1'b0, 16'h0000, "none"});
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clk);
    frame(1'b1, OFS_DEC, 8'(DEC), 1'b0, 16'h0000, "none");
    // updates at the old setting leave the ready flag up; a frame clears it first
    frame(1'b0, 7'h00, 8'h00, 1'b0, 16'h0000, "none");
    wait_ready(t1);
    frame(1'b0, 7'h00, 8'h00, 1'b0, 16'h0000, "none");
    wait_ready(t2);
    check("update interval", 32'(t2 - t1), 32'((DEC + 1) * P));
    check("sample period", 32'((t2 - t1) / (DEC + 1)), 32'(P));
    for (int i = 0; i < 3; i++)
    begin
      frame(1'b0, OFS_ACCEL_LOW[i], 8'h00, 1'b1, acc_exp[i][15:0], "accel low");
      frame(1'b0, OFS_ACCEL_HIGH[i], 8'h00, 1'b1, acc_exp[i][31:16], "accel high");
    end
    frame(1'b0, OFS_RATE_LOW[1], 8'h00, 1'b1, sample_i.rate[1][15:0], "rate low");
    frame(1'b0, OFS_RATE_HIGH[1], 8'h00, 1'b1, sample_i.rate[1][31:16], "rate high");
    frame(1'b1, OFS_ACCEL_HIGH[0], 8'h55, 1'b0, 16'h0000, "none");
    frame(1'b0, OFS_ACCEL_HIGH[0], 8'h00, 1'b1, acc_exp[0][31:16], "read only");
    frame(1'b0, OFS_TEMP, 8'h00, 1'b1, sample_i.temp, "temperature");
    frame(1'b0, OFS_TSTAMP, 8'h00, 1'b1, 16'h0000, "stamp unscaled");
    frame(1'b0, 7'h40, 8'h00, 1'b1, 16'h0000, "unmapped");
    frame(1'b0, OFS_DANG_LOW[0], 8'h00, 1'b1, dang[15:0], "dangle low");
    frame(1'b0, OFS_DANG_HIGH[0], 8'h00, 1'b1, dang[31:16], "dangle high");
    frame(1'b0, OFS_COUNT, 8'h00, 1'b0, 16'h0000, "none");
    frame(1'b1, OFS_MISC, 8'(SYNC_MODE_SCALED) << MISC_SYNC_LSB, 1'b0, 16'h0000, "none");
    cnt1 = rx_word;
    wait_ready(t1);
    frame(1'b0, OFS_COUNT, 8'h00, 1'b1, cnt1 + 16'h0001, "counter step");
    frame(1'b0, 7'h00, 8'h00, 1'b0, 16'h0000, "none");
    // sync edge placed five and a half stamp steps before the next update
    while (cyc < t1 + (DEC + 1) * P - 5 * TS_LSB_CYC - TS_LSB_CYC / 2)
      @(posedge clk);
    sync_in <= 1'b1;
    repeat (4) @(posedge clk);
    sync_in <= 1'b0;
    wait_ready(t2);
    frame(1'b0, OFS_TSTAMP, 8'h00, 1'b1, 16'h0005, "stamp scaled");
    frame(1'b1, OFS_CMD, 8'h01 << CMD_SRST_BIT, 1'b0, 16'h0000, "none");
    frame(1'b0, OFS_COUNT, 8'h00, 1'b1, COUNT_RST, "counter cleared");
    frame(1'b0, 7'h00, 8'h00, 1'b0, 16'h0000, "none");
    repeat (4) @(posedge clk);
    summarize();
  end
endmodule : iod_output_regs_bench
`default_nettype wire
